// ### inc/aclink_ctrl_pkg.sv
// package with register map, field positions and bus carriers for the ac-link control block
`default_nettype none
package aclink_ctrl_pkg;
    // ========================================
    // register map
    localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET = 8'h04;
    localparam logic [7:0]  MASK_OFFSET   = 8'h08;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK    = 32'h0007_000F;
    localparam logic [2:0]  MASK_RESET    = 3'h0;
    // ========================================
    // field positions
    localparam int BIT_COLD_RESET_DONE_EN = 18;
    localparam int BIT_STATUS_READY_EN    = 17;
    localparam int BIT_COMMAND_DONE_EN    = 16;
    localparam int BIT_SDATA_OUT_VALUE    = 3;
    localparam int BIT_CODEC_RESET_DRIVE  = 2;
    localparam int BIT_SYNC_VALUE         = 1;
    localparam int BIT_MANUAL_OVERRIDE    = 0;
    localparam int EVENT_COUNT            = 3;
    // ========================================
    // bus carriers
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_type;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] dat;
    } wb_rsp_type;

    typedef struct packed {
        logic sync;
        logic sdata_out;
    } link_pins_type;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_type;
endpackage : aclink_ctrl_pkg
`default_nettype wire

// ### hw/aclink_pin_override_irq_ctrl.sv
// ac-link pin override, codec reset drive and interrupt enable control
//
// Notes on behaviour
// - writes to bits 31:19 and 15:4 ignored; they read as zero
// - settings act only in ac-link format, not in the alternative formats
// - with override set, serial data out follows bit 3; otherwise bit ignored
// - in ac-link format, bit 2 set drives codec reset pin low
// - reading bit 1 returns the actual sync pin level
// - writing bit 1 drives sync only while override is set
// - bit 0 selects serializer or software bits as source of sync and data out
`default_nettype none
module aclink_pin_override_irq_ctrl (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          ce_i,
    input  wire aclink_ctrl_pkg::wb_req_type   wb_req_i,
    output var  aclink_ctrl_pkg::wb_rsp_type   wb_rsp_o,
    input  wire logic                          aclink_mode_i,
    input  wire aclink_ctrl_pkg::link_pins_type serializer_pins_i,
    input  wire logic [2:0]                    event_pulse_i,
    output var  aclink_ctrl_pkg::link_pins_type link_pins_o,
    output logic                               codec_reset_n_o,
    output logic [2:0]                         event_irq_o,
    output logic                               irq_o
);
    import aclink_ctrl_pkg::*;

    // ========================================
    // declarations
    bus_state_type       bus_q;
    logic [31:0]         ctrl_q;
    logic [31:0]         ctrl_d;
    logic [2:0]          status_q;
    logic [2:0]          mask_q;
    logic [31:0]         rdata_d;
    logic [31:0]         rdata_q;
    logic                err_q;
    logic                req_new;
    logic                wr_fire;
    logic                known_adr;
    logic [31:0]         byte_mask;
    link_pins_type       pins_d;
    link_pins_type       pins_q;
    logic                reset_n_q;
    logic [2:0]          event_irq_q;
    logic [2:0]          irq_enable;

    // ========================================
    // helpers
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction : lane_mask

    function automatic logic adr_hit(input logic [7:0] adr, input logic [7:0] off);
        return adr == off;
    endfunction : adr_hit

    // ========================================
    // wishbone slave: one wait state, ack (err for unknown address) then drop
    assign req_new   = wb_req_i.cyc && wb_req_i.stb && (bus_q == BUS_IDLE);
    assign wr_fire   = req_new && wb_req_i.we;
    assign known_adr = adr_hit(wb_req_i.adr, CTRL_OFFSET)
                    || adr_hit(wb_req_i.adr, STATUS_OFFSET)
                    || adr_hit(wb_req_i.adr, MASK_OFFSET);
    assign byte_mask = lane_mask(wb_req_i.sel);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_q <= BUS_IDLE;
            err_q <= 1'b0;
        end else if (ce_i) begin
            case (bus_q)
                BUS_IDLE: begin
                    if (req_new) begin
                        bus_q <= BUS_ACK;
                        err_q <= !known_adr;
                    end
                end
                BUS_ACK: begin
                    bus_q <= BUS_IDLE;
                    err_q <= 1'b0;
                end
                default: begin
                    bus_q <= BUS_IDLE;
                    err_q <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        wb_rsp_o.ack = (bus_q == BUS_ACK) && !err_q;
        wb_rsp_o.err = (bus_q == BUS_ACK) && err_q;
        wb_rsp_o.dat = rdata_q;
    end

    // ========================================
    // control register
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_fire && adr_hit(wb_req_i.adr, CTRL_OFFSET)) begin
            ctrl_d = (ctrl_q & ~(byte_mask & CTRL_WMASK))
                   | (wb_req_i.dat & byte_mask & CTRL_WMASK);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RESET;
        end else if (ce_i) begin
            ctrl_q <= ctrl_d;
        end
    end

    // ========================================
    // read data
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (adr_hit(wb_req_i.adr, CTRL_OFFSET)) begin
            rdata_d = ctrl_q & CTRL_WMASK;
            rdata_d[BIT_SYNC_VALUE] = pins_q.sync;
        end else if (adr_hit(wb_req_i.adr, STATUS_OFFSET)) begin
            rdata_d[EVENT_COUNT-1:0] = status_q;
        end else if (adr_hit(wb_req_i.adr, MASK_OFFSET)) begin
            rdata_d[EVENT_COUNT-1:0] = mask_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (ce_i && req_new) begin
            rdata_q <= wb_req_i.we ? 32'h0000_0000 : rdata_d;
        end
    end

    // ========================================
    // pin drive
    always_comb begin
        pins_d = serializer_pins_i;
        if (aclink_mode_i && ctrl_q[BIT_MANUAL_OVERRIDE]) begin
            pins_d.sync      = ctrl_q[BIT_SYNC_VALUE];
            pins_d.sdata_out = ctrl_q[BIT_SDATA_OUT_VALUE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_q    <= '0;
            reset_n_q <= 1'b1;
        end else if (ce_i) begin
            pins_q    <= pins_d;
            reset_n_q <= !(aclink_mode_i && ctrl_q[BIT_CODEC_RESET_DRIVE]);
        end
    end

    assign link_pins_o     = pins_q;
    assign codec_reset_n_o = reset_n_q;

    // ========================================
    // events and interrupts
    assign irq_enable = {ctrl_q[BIT_COLD_RESET_DONE_EN],
                         ctrl_q[BIT_STATUS_READY_EN],
                         ctrl_q[BIT_COMMAND_DONE_EN]};

    genvar g;
    generate
        for (g = 0; g < EVENT_COUNT; g++) begin : g_event
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    status_q[g] <= 1'b0;
                end else if (ce_i) begin
                    if (event_pulse_i[g]) begin
                        status_q[g] <= 1'b1;
                    end else if (wr_fire && adr_hit(wb_req_i.adr, STATUS_OFFSET)
                                 && wb_req_i.sel[0] && wb_req_i.dat[g]) begin
                        status_q[g] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    event_irq_q[g] <= 1'b0;
                end else if (ce_i) begin
                    event_irq_q[g] <= status_q[g] && irq_enable[g]
                                      && aclink_mode_i;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= MASK_RESET;
        end else if (ce_i && wr_fire && adr_hit(wb_req_i.adr, MASK_OFFSET)
                     && wb_req_i.sel[0]) begin
            mask_q <= wb_req_i.dat[EVENT_COUNT-1:0];
        end
    end

    assign event_irq_o = event_irq_q;
    assign irq_o       = |(event_irq_q & mask_q);
endmodule : aclink_pin_override_irq_ctrl
`default_nettype wire

// ### tb/aclink_ctrl_properties.sv
// port checker of the ac-link control block
`default_nettype none
module aclink_ctrl_properties (
    input wire logic                           clk_i,
    input wire logic                           rst_i,
    input wire aclink_ctrl_pkg::wb_req_type    wb_req_i,
    input wire aclink_ctrl_pkg::wb_rsp_type    wb_rsp_o,
    input wire logic                           aclink_mode_i,
    input wire aclink_ctrl_pkg::link_pins_type serializer_pins_i,
    input wire aclink_ctrl_pkg::link_pins_type link_pins_o,
    input wire logic                           codec_reset_n_o,
    input wire logic [2:0]                     event_irq_o,
    input wire logic                           irq_o
);
    import aclink_ctrl_pkg::*;
    wire ctl = wb_rsp_o.ack && wb_req_i.adr == CTRL_OFFSET;
    wire cw = ctl && wb_req_i.we && wb_req_i.sel[0] && aclink_mode_i;
    wire off = !aclink_mode_i && !rst_i;
    wire [1:0] sw = {wb_req_i.dat[1], wb_req_i.dat[3]};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ========================================
    // assertions
    chk_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held");
    chk_rsvd_zero: assert property (
        ctl && !wb_req_i.we |-> (wb_rsp_o.dat & ~CTRL_WMASK) == 32'h0000_0000)
        else $error("reserved bits set");
    chk_sync_readback: assert property (
        ctl && !wb_req_i.we |-> wb_rsp_o.dat[1] == $past(link_pins_o.sync))
        else $error("sync readback");
    chk_serial_source: assert property (
        $past(off) |-> (link_pins_o == $past(serializer_pins_i)) && codec_reset_n_o)
        else $error("pins outside link mode");
    chk_reset_drive: assert property (cw |=> codec_reset_n_o == !$past(wb_req_i.dat[2]))
        else $error("codec reset");
    chk_manual_pins: assert property (
        cw |=> link_pins_o == ($past(wb_req_i.dat[0]) ? $past(sw) : $past(serializer_pins_i)))
        else $error("pin source");
    chk_irq_any: assert property (irq_o |-> event_irq_o != 3'h0)
        else $error("irq without event");
    chk_irq_mode: assert property ($past(off) |-> event_irq_o == 3'h0)
        else $error("event irq outside link mode");
    cover property (cw && wb_req_i.dat[0]);
    cover property (irq_o);
    cover property (wb_rsp_o.err);
endmodule : aclink_ctrl_properties
bind aclink_pin_override_irq_ctrl aclink_ctrl_properties u_aclink_ctrl_properties (.clk_i, .rst_i,
    .wb_req_i, .wb_rsp_o, .aclink_mode_i, .serializer_pins_i, .link_pins_o, .codec_reset_n_o,
    .event_irq_o, .irq_o);
`default_nettype wire

// ### tb/aclink_codec_model.sv
// codec model: reports cold reset done when its reset pin is released
`default_nettype none
module aclink_codec_model (
    input  wire logic clk_i,
    input  wire logic codec_reset_n_i,
    output logic      cold_done_o
);
    logic held_q;
    always_ff @(posedge clk_i) begin
        held_q      <= codec_reset_n_i;
        cold_done_o <= codec_reset_n_i && !held_q;
    end
endmodule : aclink_codec_model
`default_nettype wire

// ### tb/aclink_pin_override_irq_ctrl_tb.sv
// testbench of the ac-link control block
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error at %0t: got %0h exp %0h", $time, a, b); end end
module aclink_pin_override_irq_ctrl_tb;
    import aclink_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic          clk_i = 1'b0;
    logic          rst_i = 1'b1;
    wb_req_type    req = '0;
    wb_rsp_type    rsp;
    logic          mode = 1'b1;
    link_pins_type ser = '0;
    link_pins_type pins;
    logic [1:0]    ev_q = '0;
    logic          cold, rst_n, irq;
    logic [2:0]    eirq;
    logic [32:0]   r;
    int            error_cnt = 0;
    int            cmp_count = 0;
    aclink_pin_override_irq_ctrl u_aclink_pin_override_irq_ctrl (.clk_i, .rst_i, .ce_i(1'b1),
        .wb_req_i(req), .wb_rsp_o(rsp), .aclink_mode_i(mode), .serializer_pins_i(ser),
        .event_pulse_i({cold, ev_q}), .link_pins_o(pins), .codec_reset_n_o(rst_n),
        .event_irq_o(eirq), .irq_o(irq));
    aclink_codec_model u_aclink_codec_model (.clk_i, .codec_reset_n_i(rst_n), .cold_done_o(cold));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // ========================================
    // bus, pin check and end-of-run tasks
    task automatic complete_run();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, 4'hF, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (!rsp.ack && !rsp.err && n < 20);
        r = {rsp.err, rsp.dat};
        if (!rsp.ack && !rsp.err) begin
            error_cnt++;
            complete_run();
        end
        req <= '0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(r, e)
    endtask : rd
    task automatic pin(input logic [2:0] e);
        @(posedge clk_i);
        @(negedge clk_i);
        `CHK({pins, rst_n}, e)
    endtask : pin
    // ========================================
    // scenarios
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CTRL_OFFSET, 33'h0);
        pin(3'b001);
        bus(1'b1, CTRL_OFFSET, 32'hFFFF_FFFF);
        rd(CTRL_OFFSET, 33'h0_0007_000F);
        pin(3'b110);
        bus(1'b1, CTRL_OFFSET, 32'h0000_000A);
        pin(3'b001);
        rd(CTRL_OFFSET, 33'h0_0000_0008);
        ser <= 2'b10;
        rd(CTRL_OFFSET, 33'h0_0000_000A);
        mode <= 1'b0;
        bus(1'b1, CTRL_OFFSET, 32'h0000_000F);
        pin(3'b101);
        mode <= 1'b1;
        pin(3'b110);
        bus(1'b1, MASK_OFFSET, 32'h7);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, CTRL_OFFSET, 32'h4 | (32'h1 << (16 + i)));
            bus(1'b1, CTRL_OFFSET, 32'h1 << (16 + i));
            @(posedge clk_i);
            ev_q <= 2'b11;
            @(posedge clk_i);
            ev_q <= 2'b00;
            rd(STATUS_OFFSET, 33'h7);
            @(negedge clk_i);
            `CHK({eirq, irq}, {3'h1 << i, 1'b1})
            bus(1'b1, MASK_OFFSET, 32'h0);
            @(negedge clk_i);
            `CHK(irq, 1'b0)
            bus(1'b1, MASK_OFFSET, 32'h7);
            bus(1'b1, STATUS_OFFSET, 32'h7);
            rd(STATUS_OFFSET, 33'h0);
        end
        bus(1'b0, 8'h0C, 32'h0);
        `CHK(r[32], 1'b1)
        complete_run();
    end
endmodule : aclink_pin_override_irq_ctrl_tb
`default_nettype wire
